// file: rtl/rtg_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "rtg_cfg.svh"
module rtg_top #(
  parameter int DIV_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // pins and converter events
  input wire logic lowFreqOscPin,
  input wire logic [3:0] gpPortPin,
  input wire logic capConvDone,
  input wire logic prechargeActive,
  // guard amplifier
  output logic guardToAmp,
  output logic [1:0] guardGainSel,
  output logic [1:0] guardAttenuationSel,
  output logic [2:0] guardCurrentTrim,
  // temperature converter
  output logic tempBusy,
  output logic tempWarmup,
  output logic tempSampleStrobe,
  output logic tempDone,
  output logic [3:0] tempPortEnable
);
  logic [7:0] cfgReg [0:6];
  logic [7:0] cfgIdx;
  logic cfgHit;
  logic [3:0] guardTime;
  logic tempCycleDouble;
  logic [DIV_W-1:0] tempTriggerDivider;
  logic [2:0] tempTriggerSource;
  logic [1:0] tempAverageDepth;
  logic tempFakeLong;
  logic [1:0] tempStartPinSel;
  logic [4:0] sync1_reg, sync2_reg, sync3_reg, pinLevel_reg;
  logic lfoTick;
  logic [3:0] pinRise;
  logic trigEvent, trigPass;
  rtg_pkg::rtg_seq_t state_reg;
  logic tick_reg;
  logic [4:0] cycCnt_reg;
  logic cycleEnd;
  logic [4:0] warmNum, avgNum;
  logic prechPrev_reg;
  logic prechRise;
  logic [8:0] guardSpan, guardCnt_reg;

  // field extraction
  assign guardTime = cfgReg[0][`RTG_GTIME_HI:0];
  assign tempCycleDouble = cfgReg[1][`RTG_CYDBL_BIT];
  assign tempTriggerDivider = {cfgReg[3][`RTG_DIVHI_HI:0], cfgReg[2]};
  assign tempTriggerSource = cfgReg[3][`RTG_TSEL_HI:`RTG_TSEL_LO];
  assign tempAverageDepth = cfgReg[3][`RTG_AVG_HI:`RTG_AVG_LO];
  assign tempFakeLong = cfgReg[4][`RTG_FAKE_BIT];
  assign tempStartPinSel = cfgReg[4][`RTG_SPIN_HI:0];

  // register decode
  assign cfgIdx = regAddr - `RTG_OFS_GUARD;
  assign cfgHit = (regAddr >= `RTG_OFS_GUARD) && (regAddr <= `RTG_OFS_TUNE2);

  // configuration writes; tuning words are stored but steer nothing here
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 7; i++) begin
        cfgReg[i] <= `RTG_CFG_RESET;
      end
    end else if (regWrite && cfgHit) begin
      cfgReg[cfgIdx[2:0]] <= regWdata;
    end
  end

  // read data stand for the cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead && cfgHit) begin
      regRdata <= cfgReg[cfgIdx[2:0]];
    end else if (regRead && regAddr == `RTG_OFS_STATUS) begin
      regRdata <= {tempBusy, tempWarmup, state_reg == rtg_pkg::ST_ARM, cycCnt_reg};
    end else begin
      regRdata <= 8'h00;
    end
  end

  // guard settings straight from the register flops
  assign guardGainSel = cfgReg[0][`RTG_GAIN_HI:`RTG_GAIN_LO];
  assign guardAttenuationSel = cfgReg[0][`RTG_ATTN_HI:`RTG_ATTN_LO];
  assign guardCurrentTrim = cfgReg[1][`RTG_TRIM_HI:0];

  // three-stage synchroniser for oscillator and pins; a change counts once stages 2 and 3 agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      pinLevel_reg <= 5'h00;
    end else begin
      sync1_reg <= {gpPortPin, lowFreqOscPin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 5; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pinLevel_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // rising edges of the filtered levels
  assign lfoTick = sync3_reg[0] && (sync2_reg[0] == sync3_reg[0]) && !pinLevel_reg[0];
  assign pinRise = sync3_reg[4:1] & ~(sync2_reg[4:1] ^ sync3_reg[4:1]) & ~pinLevel_reg[4:1];

  // trigger source mux; undefined codes raise nothing
  always_comb begin
    case (tempTriggerSource)
      rtg_pkg::TRG_TIMER: trigEvent = lfoTick;
      rtg_pkg::TRG_PIN: trigEvent = pinRise[tempStartPinSel];
      rtg_pkg::TRG_CAP_ASYNC: trigEvent = capConvDone;
      rtg_pkg::TRG_CAP_SYNC: trigEvent = capConvDone;
      default: trigEvent = 1'b0;
    endcase
  end

  // one divider serves both trigger thinning and oscillator division
  rtg_prediv #(
    .W(DIV_W)
  ) u_prediv (
    .core_clk(core_clk),
    .rstn(rstn),
    .trigIn(trigEvent),
    .divisor(tempTriggerDivider),
    .trigPass(trigPass)
  );

  // cycle counts
  assign warmNum = tempFakeLong ? `RTG_WARM_LONG : `RTG_WARM_SHORT;
  always_comb begin
    case (tempAverageDepth)
      2'h0: avgNum = 5'h01;
      2'h1: avgNum = 5'h04;
      2'h2: avgNum = 5'h08;
      2'h3: avgNum = 5'h10;
      default: avgNum = 5'h01;
    endcase
  end

  // a cycle is one oscillator period, or two with the double bit set
  assign cycleEnd = lfoTick && (tick_reg == tempCycleDouble);

  // measurement sequencer; triggers arriving while busy are dropped
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= rtg_pkg::ST_IDLE;
      cycCnt_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      case (state_reg)
        rtg_pkg::ST_IDLE: begin
          tick_reg <= 1'b0;
          cycCnt_reg <= 5'h00;
          if (trigPass && tempTriggerSource == rtg_pkg::TRG_CAP_SYNC) begin
            state_reg <= rtg_pkg::ST_ARM;
          end else if (trigPass) begin
            state_reg <= rtg_pkg::ST_WARM;
          end
        end
        rtg_pkg::ST_ARM: begin
          // synchronous start waits for the oscillator edge
          if (lfoTick) begin
            state_reg <= rtg_pkg::ST_WARM;
          end
        end
        rtg_pkg::ST_WARM: begin
          if (lfoTick) begin
            tick_reg <= cycleEnd ? 1'b0 : 1'b1;
          end
          if (cycleEnd) begin
            if (cycCnt_reg == warmNum - 5'h01) begin
              state_reg <= rtg_pkg::ST_SAMPLE;
              cycCnt_reg <= 5'h00;
            end else begin
              cycCnt_reg <= cycCnt_reg + 5'h01;
            end
          end
        end
        rtg_pkg::ST_SAMPLE: begin
          if (lfoTick) begin
            tick_reg <= cycleEnd ? 1'b0 : 1'b1;
          end
          if (cycleEnd) begin
            if (cycCnt_reg == avgNum - 5'h01) begin
              state_reg <= rtg_pkg::ST_IDLE;
              cycCnt_reg <= 5'h00;
            end else begin
              cycCnt_reg <= cycCnt_reg + 5'h01;
            end
          end
        end
        default: state_reg <= rtg_pkg::ST_IDLE;
      endcase
    end
  end

  // result strobes; warm-up cycles never strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tempSampleStrobe <= 1'b0;
      tempDone <= 1'b0;
    end else begin
      tempSampleStrobe <= (state_reg == rtg_pkg::ST_SAMPLE) && cycleEnd;
      tempDone <= (state_reg == rtg_pkg::ST_SAMPLE) && cycleEnd && (cycCnt_reg == avgNum - 5'h01);
    end
  end

  // status and port drive
  assign tempBusy = (state_reg == rtg_pkg::ST_WARM) || (state_reg == rtg_pkg::ST_SAMPLE);
  assign tempWarmup = (state_reg == rtg_pkg::ST_WARM);
  // ports only driven while a measurement runs
  assign tempPortEnable = tempBusy ? cfgReg[4][`RTG_PORT_HI:`RTG_PORT_LO] : 4'h0;

  // guard switch-over timer, restarted by each precharge
  assign prechRise = prechargeActive && !prechPrev_reg;
  assign guardSpan = 9'(32'(guardTime) * `RTG_GUARD_STEP_CYC);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prechPrev_reg <= 1'b0;
      guardCnt_reg <= 9'h000;
    end else begin
      prechPrev_reg <= prechargeActive;
      if (prechRise) begin
        guardCnt_reg <= (guardSpan == 9'h000) ? 9'h000 : guardSpan - 9'h001;
      end else if (guardCnt_reg != 9'h000) begin
        guardCnt_reg <= guardCnt_reg - 9'h001;
      end
    end
  end
  // direct connection for exactly guardSpan cycles from the precharge edge
  assign guardToAmp = !prechargeActive || (prechRise ? (guardSpan == 9'h000)
                                                      : (guardCnt_reg == 9'h000));

  // checking helpers
  logic [8:0] dirAge_reg;
  logic [4:0] warmSeen_reg, sampSeen_reg;
  logic [2:0] ticksInCycle_reg;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dirAge_reg <= 9'h000;
      warmSeen_reg <= 5'h00;
      sampSeen_reg <= 5'h00;
      ticksInCycle_reg <= 3'h0;
    end else begin
      dirAge_reg <= prechRise ? 9'h001 : (dirAge_reg + 9'h001);
      if (state_reg == rtg_pkg::ST_IDLE) begin
        warmSeen_reg <= 5'h00;
        sampSeen_reg <= 5'h00;
      end else begin
        if (tempWarmup && cycleEnd) warmSeen_reg <= warmSeen_reg + 5'h01;
        if (state_reg == rtg_pkg::ST_SAMPLE && cycleEnd) sampSeen_reg <= sampSeen_reg + 5'h01;
      end
      if (!tempBusy || cycleEnd) begin
        ticksInCycle_reg <= 3'h0;
      end else if (lfoTick) begin
        ticksInCycle_reg <= ticksInCycle_reg + 3'h1;
      end
    end
  end

  a_guard_direct_span: assert property (@(posedge core_clk) disable iff (!rstn)
    prechargeActive && !prechRise && $rose(guardToAmp) && $stable(guardTime)
    |-> dirAge_reg == guardSpan)
    else $error("guard handed to amplifier at wrong time");
  a_guard_zero_time: assert property (@(posedge core_clk) disable iff (!rstn)
    prechRise && guardTime == 4'h0 |-> guardToAmp)
    else $error("guard held direct with zero guard time");
  a_guard_gain_map: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == `RTG_OFS_GUARD |=> guardGainSel == $past(regWdata[7:6]))
    else $error("guard gain does not follow written field");
  a_cycle_ticks: assert property (@(posedge core_clk) disable iff (!rstn)
    tempBusy && cycleEnd |-> ticksInCycle_reg == 3'(tempCycleDouble))
    else $error("temperature cycle length wrong");
  a_trig_off_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == rtg_pkg::ST_IDLE && tempTriggerSource == 3'h0 |=> state_reg == rtg_pkg::ST_IDLE)
    else $error("measurement started with trigger off");
  a_cap_end_start: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == rtg_pkg::ST_IDLE && capConvDone && tempTriggerSource == 3'h5
    && tempTriggerDivider <= 10'h001 |=> tempBusy)
    else $error("conversion end did not start measurement");
  a_sync_waits_osc: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == rtg_pkg::ST_ARM && !lfoTick |=> state_reg == rtg_pkg::ST_ARM)
    else $error("synchronous start left before oscillator edge");
  a_avg_samples: assert property (@(posedge core_clk) disable iff (!rstn)
    tempDone |-> sampSeen_reg == $past(avgNum))
    else $error("wrong number of averaged samples");
  a_warm_count: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(tempWarmup) && tempBusy |-> warmSeen_reg == $past(warmNum))
    else $error("wrong number of warm-up cycles");
  a_port_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    tempBusy |-> tempPortEnable == {cfgReg[4][7], cfgReg[4][6], cfgReg[4][5], cfgReg[4][4]})
    else $error("port enables do not follow configuration");
  a_port_idle_off: assert property (@(posedge core_clk) disable iff (!rstn)
    !tempBusy |-> tempPortEnable == 4'h0)
    else $error("port driven outside a measurement");
  a_pin_select: assert property (@(posedge core_clk) disable iff (!rstn)
    tempTriggerSource == 3'h3 && trigEvent |-> pinRise[tempStartPinSel])
    else $error("unselected pin raised a trigger");
  a_osc_divided: assert property (@(posedge core_clk) disable iff (!rstn)
    tempTriggerSource == 3'h1 && trigPass |-> lfoTick)
    else $error("timer trigger not from oscillator");

  c_cap_start: cover property (@(posedge core_clk) disable iff (!rstn)
    capConvDone && state_reg == rtg_pkg::ST_IDLE ##1 tempBusy);
  c_pin_start: cover property (@(posedge core_clk) disable iff (!rstn)
    tempTriggerSource == 3'h3 && trigPass);
  c_long_warm: cover property (@(posedge core_clk) disable iff (!rstn)
    tempFakeLong && $fell(tempWarmup));
  c_done_avg16: cover property (@(posedge core_clk) disable iff (!rstn)
    tempDone && tempAverageDepth == 2'h3);
endmodule // rtg_top
`default_nettype wire

// file: rtl/rtg_cfg.svh
`ifndef RTG_CFG_SVH
`define RTG_CFG_SVH

// register offsets
`define RTG_OFS_GUARD 8'h13
`define RTG_OFS_CYCLE 8'h14
`define RTG_OFS_DIVLO 8'h15
`define RTG_OFS_TRIG 8'h16
`define RTG_OFS_PORT 8'h17
`define RTG_OFS_TUNE1 8'h18
`define RTG_OFS_TUNE2 8'h19
`define RTG_OFS_STATUS 8'h30
`define RTG_CFG_RESET 8'h00

// field positions
`define RTG_GAIN_HI 7
`define RTG_GAIN_LO 6
`define RTG_ATTN_HI 5
`define RTG_ATTN_LO 4
`define RTG_GTIME_HI 3
`define RTG_CYDBL_BIT 7
`define RTG_TRIM_HI 2
`define RTG_TSEL_HI 6
`define RTG_TSEL_LO 4
`define RTG_AVG_HI 3
`define RTG_AVG_LO 2
`define RTG_DIVHI_HI 1
`define RTG_PORT_HI 7
`define RTG_PORT_LO 4
`define RTG_FAKE_BIT 2
`define RTG_SPIN_HI 1

// timing and counts
`define RTG_CLK_PERIOD_NS 25
`define RTG_GUARD_STEP_NS 500
`define RTG_GUARD_STEP_CYC ((`RTG_GUARD_STEP_NS + `RTG_CLK_PERIOD_NS - 1) / `RTG_CLK_PERIOD_NS)
`define RTG_WARM_SHORT 5'h02
`define RTG_WARM_LONG 5'h08

`endif

// file: rtl/rtg_pkg.sv
package rtg_pkg;
  // measurement sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_WARM = 2'b10,
    ST_SAMPLE = 2'b11
  } rtg_seq_t;
  // trigger source codes
  typedef enum logic [2:0] {
    TRG_OFF = 3'b000,
    TRG_TIMER = 3'b001,
    TRG_PIN = 3'b011,
    TRG_CAP_ASYNC = 3'b101,
    TRG_CAP_SYNC = 3'b110
  } rtg_trig_t;
endpackage

// file: rtl/rtg_prediv.sv
`timescale 1ns/10ps
`default_nettype none
module rtg_prediv #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // trigger in, divider value, passed trigger
  input wire logic trigIn,
  input wire logic [W-1:0] divisor,
  output logic trigPass
);
  logic [W-1:0] cnt_reg;

  // 0 and 1 both mean no division; >= guards a divisor lowered mid-count
  always_comb begin
    trigPass = trigIn && ((divisor <= W'(1)) || (cnt_reg >= divisor - W'(1)));
  end

  // count swallowed triggers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (trigPass) begin
      cnt_reg <= '0;
    end else if (trigIn) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  a_prediv_bypass: assert property (@(posedge core_clk) disable iff (!rstn)
    trigIn && divisor <= W'(1) |-> trigPass)
    else $error("divider swallowed a trigger at divisor 0 or 1");
  a_prediv_swallow: assert property (@(posedge core_clk) disable iff (!rstn)
    trigIn && !trigPass |=> cnt_reg == $past(cnt_reg) + W'(1))
    else $error("divider did not count a swallowed trigger");
  a_prediv_nth: assert property (@(posedge core_clk) disable iff (!rstn)
    trigPass && divisor > W'(1) && $stable(divisor) |-> cnt_reg == divisor - W'(1))
    else $error("divider passed before the nth trigger");
endmodule // rtg_prediv
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int P = 40; // core cycles per oscillator period
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic lowFreqOscPin = 1'b0;
  logic [3:0] gpPortPin = 4'h0;
  logic capConvDone = 1'b0;
  logic prechargeActive = 1'b0;
  logic guardToAmp;
  logic [1:0] guardGainSel;
  logic [1:0] guardAttenuationSel;
  logic [2:0] guardCurrentTrim;
  logic tempBusy;
  logic tempWarmup;
  logic tempSampleStrobe;
  logic tempDone;
  logic [3:0] tempPortEnable;
  int err_total = 0;
  int samples_checked = 0;
  int oscCnt = 0;

  always #12.5 core_clk = ~core_clk;

  // free-running slow oscillator; unrelated to any trigger so start phase varies
  always @(posedge core_clk) begin
    oscCnt <= (oscCnt == P / 2 - 1) ? 0 : oscCnt + 1;
    if (oscCnt == P / 2 - 1) lowFreqOscPin <= ~lowFreqOscPin;
  end

  rtg_top u_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .lowFreqOscPin(lowFreqOscPin), .gpPortPin(gpPortPin), .capConvDone(capConvDone),
    .prechargeActive(prechargeActive), .guardToAmp(guardToAmp), .guardGainSel(guardGainSel),
    .guardAttenuationSel(guardAttenuationSel), .guardCurrentTrim(guardCurrentTrim),
    .tempBusy(tempBusy), .tempWarmup(tempWarmup), .tempSampleStrobe(tempSampleStrobe),
    .tempDone(tempDone), .tempPortEnable(tempPortEnable));

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // oscillator-timed lengths shift by a few cycles through the pin synchroniser
  task automatic chkNear(input string name, input int exp, input int got);
    samples_checked++;
    if (got < exp - 3 || got > exp + 3) begin
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk("rdata", {8'h00, exp}, {8'h00, regRdata});
    @(posedge core_clk);
    #1 chk("rdataIdle", 16'h0000, {8'h00, regRdata});
  endtask

  function automatic logic cur(input int w);
    case (w)
      0: return tempBusy;
      1: return tempWarmup;
      2: return guardToAmp;
      default: return tempDone;
    endcase
  endfunction

  // bounded wait, sampled just after each edge
  task automatic waitVal(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (cur(w) !== v) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > lim) begin
        $display("mismatch wait%0d expected %b seen %b", w, v, cur(w));
        err_total++;
        finish_test();
      end
    end
  endtask

  task automatic pulseDone();
    @(posedge core_clk);
    capConvDone <= 1'b1;
    @(posedge core_clk);
    capConvDone <= 1'b0;
    #1;
  endtask

  task automatic regTest();
    for (int a = 8'h13; a <= 8'h19; a++) rd(8'(a), 8'h00);
    for (int a = 8'h13; a <= 8'h1a; a++) wr(8'(a), 8'(a) ^ 8'h5a);
    for (int a = 8'h13; a <= 8'h19; a++) rd(8'(a), 8'(a) ^ 8'h5a);
    rd(8'h1a, 8'h00); // unmapped place reads zero
    wr(8'h30, 8'hff); // status is read-only, the write must be ignored
    rd(8'h30, 8'h00); // idle status: not busy, no warm-up, not armed, count zero
    wr(8'h16, 8'h00);
    wr(8'h15, 8'h00);
  endtask

  task automatic guardTest();
    int n;
    for (int g = 0; g < 4; g++) begin
      wr(8'h13, {2'(g), 2'(3 - g), 4'h2});
      chk("gain", 16'(g), {14'h0, guardGainSel});
      chk("attn", 16'(3 - g), {14'h0, guardAttenuationSel});
    end
    wr(8'h14, 8'h07);
    chk("trim", 16'h0007, {13'h0, guardCurrentTrim});
    @(posedge core_clk);
    prechargeActive <= 1'b1;
    #1 chk("guardDirect", 16'h0000, {15'h0, guardToAmp});
    waitVal(2, 1'b1, 200, n);
    chk("guardDelay", 16'd40, 16'(n));
    @(posedge core_clk);
    prechargeActive <= 1'b0;
    wr(8'h13, 8'h00);
    @(posedge core_clk);
    prechargeActive <= 1'b1;
    #1 chk("guardZero", 16'h0001, {15'h0, guardToAmp});
    @(posedge core_clk);
    prechargeActive <= 1'b0;
  endtask

  // synchronous cap-end start, so cycle lengths line up with oscillator ticks
  task automatic measure(input bit dbl, input bit warm, input logic [1:0] avg,
                         input logic [3:0] ports);
    int k, w, s, n, strobes, cyc;
    k = dbl ? 2 : 1;
    w = warm ? 8 : 2;
    s = (avg == 0) ? 1 : (avg == 1) ? 4 : (avg == 2) ? 8 : 16;
    wr(8'h15, 8'h00);
    wr(8'h14, {dbl, 7'h07});
    wr(8'h17, {ports, 1'b0, warm, 2'b00});
    wr(8'h16, {4'h6, avg, 2'b00});
    pulseDone();
    waitVal(0, 1'b1, 2 * P, n);
    chk("warmFlag", 16'h0001, {15'h0, tempWarmup});
    chk("ports", {12'h0, ports}, {12'h0, tempPortEnable});
    waitVal(1, 1'b0, w * k * P + 10, n);
    chkNear("warmLen", w * k * P, n);
    strobes = 0;
    cyc = 0;
    while (tempDone !== 1'b1) begin
      if (tempSampleStrobe === 1'b1) strobes++;
      @(posedge core_clk);
      #1;
      cyc++;
      if (cyc > s * k * P + 10) begin
        $display("mismatch doneWait expected 1 seen 0");
        err_total++;
        finish_test();
      end
    end
    if (tempSampleStrobe === 1'b1) strobes++;
    chk("strobes", 16'(s), 16'(strobes));
    chkNear("sampleLen", s * k * P, cyc);
    chk("busyEnd", 16'h0000, {15'h0, tempBusy});
    chk("portsOff", 16'h0000, {12'h0, tempPortEnable});
  endtask

  task automatic capDivTest();
    int n;
    wr(8'h15, 8'h03);
    wr(8'h17, 8'h00);
    wr(8'h14, 8'h07);
    wr(8'h16, 8'h50);
    repeat (2) begin
      pulseDone();
      chk("divHeld", 16'h0000, {15'h0, tempBusy});
      repeat (3) @(posedge core_clk);
    end
    pulseDone();
    chk("divPass", 16'h0001, {15'h0, tempBusy});
    waitVal(0, 1'b0, 12 * P, n);
    wr(8'h16, 8'h00);
  endtask

  task automatic timerTest();
    int n, m;
    wr(8'h15, 8'h04);
    wr(8'h16, 8'h10);
    waitVal(0, 1'b1, 6 * P, n);
    waitVal(0, 1'b0, 5 * P, n);
    waitVal(0, 1'b1, 5 * P, m);
    chkNear("timerPeriod", 4 * P, n + m);
    wr(8'h16, 8'h00);
    waitVal(0, 1'b0, 5 * P, n);
    wr(8'h15, 8'h00);
  endtask

  task automatic offCodes();
    logic [2:0] codes [4] = '{3'd0, 3'd2, 3'd4, 3'd7};
    logic bad;
    foreach (codes[i]) begin
      wr(8'h16, {1'b0, codes[i], 4'h0});
      pulseDone();
      bad = 1'b0;
      repeat (2 * P) begin
        @(posedge core_clk);
        #1;
        if (tempBusy !== 1'b0) bad = 1'b1;
      end
      chk("noStart", 16'h0000, {15'h0, bad});
    end
  endtask

  task automatic pinTest();
    int n;
    for (int p = 0; p < 4; p++) begin
      wr(8'h17, {6'h00, 2'(p)});
      wr(8'h16, 8'h30);
      @(posedge core_clk);
      gpPortPin <= 4'h1 << ((p + 1) % 4);
      repeat (8) @(posedge core_clk);
      #1 chk("wrongPin", 16'h0000, {15'h0, tempBusy});
      @(posedge core_clk);
      gpPortPin <= 4'h0;
      repeat (4) @(posedge core_clk);
      gpPortPin <= 4'h1 << p;
      #1;
      waitVal(0, 1'b1, 8, n);
      @(posedge core_clk);
      gpPortPin <= 4'h0;
      #1;
      waitVal(0, 1'b0, 5 * P, n);
    end
    wr(8'h16, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    regTest();
    guardTest();
    measure(1'b0, 1'b0, 2'd0, 4'h1);
    measure(1'b1, 1'b1, 2'd1, 4'h2);
    measure(1'b0, 1'b0, 2'd2, 4'h4);
    measure(1'b1, 1'b0, 2'd3, 4'h8);
    capDivTest();
    timerTest();
    offCodes();
    pinTest();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
